// ==== csbc_pkg.sv ====
// Package for the per-chip-select burst configuration block.
// Assumes a single 100 MHz system clock domain; no register bus.
package csbc_pkg;

  localparam int unsigned CSBC_CLK_MHZ = 100;
  localparam int unsigned CSBC_ADDR_W = 24;
  localparam int unsigned CSBC_DATA_W = 32;

  // Field widths and reset values
  localparam int unsigned CSBC_DLY_W = 4;
  localparam int unsigned CSBC_GAP_W = 2;
  localparam logic [CSBC_DLY_W-1:0] CSBC_DLY_RST = 4'h0;
  localparam logic [CSBC_GAP_W-1:0] CSBC_GAP_RST = 2'h0;
  localparam logic [1:0] CSBC_PAGE_RST = 2'h0;
  localparam logic [1:0] CSBC_PORT_RST = 2'h0;
  localparam logic [2:0] CSBC_ASD_RST = 3'h0;

  // Page words are 4 << code
  localparam int unsigned CSBC_PAGE_BASE_LOG2 = 2;
  // Port width codes: 0 byte, 1 halfword, 2/3 word
  localparam logic [1:0] CSBC_PORT_HALF = 2'h1;
  localparam logic [1:0] CSBC_PORT_WORD = 2'h2;

  localparam logic [CSBC_DLY_W-1:0] CSBC_DLY_ONE = 4'h1;
  localparam logic [4:0] CSBC_CNT_ONE = 5'h01;
  localparam logic [4:0] CSBC_CNT_ZERO = 5'h00;
  localparam logic [7:0] CSBC_LEN_ONE = 8'h01;

  // Configuration latched per chip select
  typedef struct packed {
    logic page_emulation_enable;
    logic sync_burst_enable;
    logic [CSBC_DLY_W-1:0] read_sample_delay;
    logic [CSBC_GAP_W-1:0] cs_min_negate_cycles;
    logic [1:0] burst_page_words;
    logic [1:0] port_width_select;
    logic [2:0] cs_assert_delay;
  } csbc_cfg_t;

  typedef struct packed {
    logic start;
    logic write;
    logic [CSBC_ADDR_W-1:0] addr;
    logic [7:0] len;
  } csbc_req_t;

  // Gray coded along idle -> addr -> wait -> data -> negate
  typedef enum logic [2:0] {
    CSBC_IDLE = 3'h0,
    CSBC_ADDR = 3'h1,
    CSBC_WAIT = 3'h3,
    CSBC_DATA = 3'h2,
    CSBC_NEG = 3'h6
  } csbc_state_t;

endpackage

// ==== csbc_chip_select_burst_config.sv ====
// Burst sequencing for one chip select: address/strobe/clock generation,
// read sampling delay, page limit and chip select negation spacing.
// Assumes config ports are static during an access and the requester
// holds a request until accepted.
// Functional notes
// [R1] Page emulation drives a new external address for every burst item.
// [R2] Page emulation makes strobe and burst clock behave like asynchronous access.
// [R3] Reset clears page emulation enable.
// [R4] Sync burst enable 1 uses burst clock, strobe and wait; 0 disables.
// [R5] Reset clears sync burst enable.
// [R6] Wait read_sample_delay cycles before latching burst data; 0 and 1 mean one.
// [R7] Sample delay has no effect when sync burst is off.
// [R8] Reset clears sample delay to one-cycle sampling.
// [R9] Chip select stays negated at least 0..3 cycles per negation field.
// [R10] Negation minimum ignored for writes when any assert-delay bit set.
// [R11] With page emulation a burst never crosses a page boundary.
// [R12] Reset clears the page size field.
// [R13] Page size codes 00..11 give 4, 8, 16, 32 words.
// [R14] With sync off the burst clock is idle and strobe is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module csbc_chip_select_burst_config
  import csbc_pkg::*;
#(
  parameter int unsigned ADDR_W = CSBC_ADDR_W,
  parameter int unsigned DATA_W = CSBC_DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration, loaded while cfg_load is high and the block is idle
  input wire logic cfg_load,
  input wire csbc_cfg_t cfg_in,
  // Access request from the bus side
  input wire csbc_req_t req,
  output logic req_ready,
  output logic [7:0] done_len,
  output logic done,
  // Read data returned
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  // External memory pins
  input wire logic [DATA_W-1:0] mem_data_in,
  input wire logic burst_wait_input,
  output logic [ADDR_W-1:0] mem_addr,
  output logic cs_n,
  output logic address_valid_strobe_n,
  output logic burst_clk
);

  typedef struct packed {
    csbc_cfg_t cfg;
    csbc_state_t st;
    logic [ADDR_W-1:0] addr;
    logic [7:0] left;
    logic [7:0] cnt_done;
    logic [4:0] cnt;
    logic write;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;
    logic w1;
    logic w2;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic ready;
    logic done;
    logic [7:0] done_len;
    logic cs_n;
    logic avs_n;
    logic bclk;
  } csbc_s_t;

  csbc_s_t s_q, s_d;

  // Words to the end of the page from a given byte address
  function automatic logic [7:0] page_room(input logic [ADDR_W-1:0] a,
                                           input logic [1:0] pcode,
                                           input logic [1:0] pwid);
    logic [ADDR_W-1:0] w;
    logic [5:0] pw;
    logic [5:0] off;
    begin
      w = (pwid == CSBC_PORT_HALF) ? (a >> 1) : (pwid >= CSBC_PORT_WORD) ? (a >> 2) : a;
      pw = 6'(1 << (CSBC_PAGE_BASE_LOG2 + 32'(pcode))); // R13
      off = 6'(w) & 6'(pw - 6'h01);
      page_room = 8'(pw - off);
    end
  endfunction

  function automatic logic [ADDR_W-1:0] step(input logic [1:0] pwid);
    begin
      step = (pwid == CSBC_PORT_HALF) ? ADDR_W'(2) :
             (pwid >= CSBC_PORT_WORD) ? ADDR_W'(4) : ADDR_W'(1);
    end
  endfunction

  logic [4:0] sample_cycles;
  logic [4:0] neg_cycles;
  logic [7:0] room;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rvalid = 1'b0;
    // Pin synchronisers; burst_wait and data are from outside the domain
    s_d.d1 = mem_data_in;
    s_d.d2 = s_q.d1;
    s_d.w1 = burst_wait_input;
    s_d.w2 = s_q.w1;
    // Codes 0 and 1 both mean one cycle; ignored when sync off
    if (s_q.cfg.sync_burst_enable && s_q.cfg.read_sample_delay > CSBC_DLY_ONE) begin // R6 R7
      sample_cycles = 5'(s_q.cfg.read_sample_delay);
    end else begin
      sample_cycles = CSBC_CNT_ONE;
    end
    // Writes with assert delay skip the negation spacing
    if (s_q.write && (s_q.cfg.cs_assert_delay != CSBC_ASD_RST)) begin // R10
      neg_cycles = CSBC_CNT_ZERO;
    end else begin
      neg_cycles = 5'(s_q.cfg.cs_min_negate_cycles); // R9
    end
    room = page_room(req.addr, s_q.cfg.burst_page_words, s_q.cfg.port_width_select);
    if (cfg_load && s_q.st == CSBC_IDLE) begin
      s_d.cfg = cfg_in;
    end
    case (s_q.st)
      CSBC_IDLE: begin
        s_d.ready = 1'b1;
        s_d.bclk = 1'b0;
        if (req.start && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.addr = req.addr;
          s_d.write = req.write;
          s_d.left = (req.len == 8'h00) ? CSBC_LEN_ONE : req.len;
          // Trim the burst at the page end
          if (s_q.cfg.page_emulation_enable && req.len > room) begin // R11
            s_d.left = room;
          end
          s_d.cnt_done = 8'h00;
          s_d.cs_n = 1'b0;
          s_d.avs_n = 1'b0;
          s_d.cnt = sample_cycles;
          s_d.st = CSBC_ADDR;
        end
      end
      CSBC_ADDR: begin
        // Strobe is one cycle wide, as in an asynchronous access
        s_d.avs_n = 1'b1; // R2 R14
        s_d.st = CSBC_WAIT;
      end
      CSBC_WAIT: begin
        // Burst clock toggles only in true sync burst
        if (s_q.cfg.sync_burst_enable && !s_q.cfg.page_emulation_enable) begin // R4 R2
          s_d.bclk = ~s_q.bclk;
        end else begin
          s_d.bclk = 1'b0; // R14
        end
        // Device wait stalls the count in sync mode only
        if (!(s_q.cfg.sync_burst_enable && s_q.w2)) begin // R4
          if (s_q.cnt > CSBC_CNT_ONE) begin
            s_d.cnt = s_q.cnt - CSBC_CNT_ONE; // R6
          end else begin
            s_d.st = CSBC_DATA;
          end
        end
      end
      CSBC_DATA: begin
        s_d.rdata = s_q.d2;
        s_d.rvalid = !s_q.write;
        s_d.left = s_q.left - CSBC_LEN_ONE;
        s_d.cnt_done = s_q.cnt_done + CSBC_LEN_ONE;
        s_d.cnt = sample_cycles;
        if (s_q.left == CSBC_LEN_ONE) begin
          s_d.cs_n = 1'b1;
          s_d.bclk = 1'b0;
          s_d.cnt = neg_cycles;
          s_d.st = CSBC_NEG;
        end else if (s_q.cfg.page_emulation_enable || !s_q.cfg.sync_burst_enable) begin
          // Fresh address and strobe per item
          s_d.addr = s_q.addr + step(s_q.cfg.port_width_select); // R1
          s_d.avs_n = 1'b0; // R2
          s_d.st = CSBC_ADDR;
        end else begin
          s_d.addr = s_q.addr + step(s_q.cfg.port_width_select);
          // One extra cycle so the synchroniser holds data of the new address
          s_d.cnt = sample_cycles + CSBC_CNT_ONE; // R6
          s_d.st = CSBC_WAIT;
        end
      end
      CSBC_NEG: begin
        if (s_q.cnt == CSBC_CNT_ZERO) begin // R9
          s_d.done = 1'b1;
          s_d.done_len = s_q.cnt_done;
          s_d.ready = 1'b1;
          s_d.st = CSBC_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - CSBC_CNT_ONE;
        end
      end
      default: begin
        s_d.st = CSBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.cfg.page_emulation_enable <= 1'b0; // R3
      s_q.cfg.sync_burst_enable <= 1'b0; // R5
      s_q.cfg.read_sample_delay <= CSBC_DLY_RST; // R8
      s_q.cfg.cs_min_negate_cycles <= CSBC_GAP_RST;
      s_q.cfg.burst_page_words <= CSBC_PAGE_RST; // R12
      s_q.cfg.port_width_select <= CSBC_PORT_RST;
      s_q.cfg.cs_assert_delay <= CSBC_ASD_RST;
      s_q.st <= CSBC_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.avs_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready = s_q.ready;
  assign done = s_q.done;
  assign done_len = s_q.done_len;
  assign rd_data = s_q.rdata;
  assign rd_valid = s_q.rvalid;
  assign mem_addr = s_q.addr;
  assign cs_n = s_q.cs_n;
  assign address_valid_strobe_n = s_q.avs_n;
  assign burst_clk = s_q.bclk;

endmodule
`default_nettype wire

// ==== csbc_checker.sv ====
// Timing checks for the chip select burst block, bound to every instance.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module csbc_checker
  import csbc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request side
  input wire logic cfg_load,
  input wire csbc_cfg_t cfg_in,
  input wire csbc_req_t req,
  input wire logic req_ready,
  input wire logic rd_valid,
  // Pins
  input wire logic [CSBC_ADDR_W-1:0] mem_addr,
  input wire logic cs_n,
  input wire logic address_valid_strobe_n,
  input wire logic burst_clk
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  csbc_cfg_t c_q;
  logic w_q, pw_q, f_q;
  logic [3:0] hi_q;
  logic [4:0] k_q, s;
  wire acc = req.start && req_ready;
  assign s = (c_q.sync_burst_enable && c_q.read_sample_delay > 4'h1) ?
    {1'b0, c_q.read_sample_delay} : 5'h01;
  // Own copy of the latched config, so checks follow what the block holds
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c_q <= '0;
      w_q <= 1'b0;
      pw_q <= 1'b0;
      f_q <= 1'b0;
      hi_q <= 4'h0;
      k_q <= 5'h00;
    end else begin
      if (cfg_load && req_ready) c_q <= cfg_in;
      if (acc) begin
        w_q <= req.write;
        pw_q <= w_q;
      end
      f_q <= acc || (f_q && !rd_valid);
      k_q <= acc ? 5'h00 : k_q + 5'h01;
      hi_q <= !cs_n ? 4'h0 : (hi_q == 4'hf ? hi_q : hi_q + 4'h1);
    end
  end
  sequence s_more;
    c_q.page_emulation_enable && rd_valid && !cs_n;
  endsequence
  AST_ACCEPT: assert property (acc |=> !cs_n && !address_valid_strobe_n && !req_ready)
    else $error("access not started after accept");
  AST_STROBE_ONE: assert property (!address_valid_strobe_n |=> address_valid_strobe_n)
    else $error("strobe longer than one cycle");
  AST_NOSYNC_BCLK: assert property (!c_q.sync_burst_enable |-> !burst_clk)
    else $error("burst clock active with sync off");
  AST_EMU_BCLK: assert property (c_q.page_emulation_enable |-> !burst_clk)
    else $error("burst clock active with page emulation");
  AST_IDLE: assert property (req_ready |-> cs_n && !burst_clk)
    else $error("pins active while idle");
  AST_NEG: assert property ($fell(cs_n) && !(pw_q && |c_q.cs_assert_delay)
    |-> hi_q >= {2'h0, c_q.cs_min_negate_cycles}) else $error("chip select gap short");
  AST_SAMPLE: assert property (rd_valid && f_q |-> k_q > s && k_q <= s + 5'h06)
    else $error("first read item at wrong time");
  AST_EMU_STROBE: assert property (s_more |-> $fell(address_valid_strobe_n) && $changed(mem_addr))
    else $error("no new address strobe per item");
endmodule
bind csbc_chip_select_burst_config csbc_checker csbc_checker_i (.clk(clk), .rstn(rstn),
  .cfg_load(cfg_load), .cfg_in(cfg_in), .req(req), .req_ready(req_ready),
  .rd_valid(rd_valid), .mem_addr(mem_addr), .cs_n(cs_n),
  .address_valid_strobe_n(address_valid_strobe_n),
  .burst_clk(burst_clk));
`default_nettype wire

// ==== csbc_mem_model.sv ====
// Memory device model: read data carries the address it was read from.
// Assumes the block holds mem_addr while an item is sampled.
`timescale 1ns/1ps
`default_nettype none
module csbc_mem_model (
  // Clock
  input wire logic clk,
  // Pins in
  input wire logic [23:0] mem_addr,
  input wire logic cs_n,
  // Bench control of the wait pin
  input wire logic wait_req,
  // Pins out
  output logic [31:0] mem_data_in,
  output logic burst_wait_input
);
  logic [31:0] last_q;
  // Deselected bus floats; a changing value stops stale data passing
  assign mem_data_in = cs_n ? ~last_q : {8'ha5, mem_addr};
  assign burst_wait_input = wait_req;
  always_ff @(posedge clk) begin
    last_q <= mem_data_in;
  end
endmodule
`default_nettype wire

// ==== csbc_chip_select_burst_config_tb_top.sv ====
// Testbench: config and access tasks, timing compared by differences.
// Assumes the memory model adds wait states only while the bench sets bw_on.
`timescale 1ns/1ps
`default_nettype none
module csbc_chip_select_burst_config_tb_top;
  import csbc_pkg::*;
  logic clk, rstn, cfg_load, rd_valid, done, req_ready, cs_n, stb_n, bclk, bw, bw_on;
  logic [7:0] done_len;
  logic [31:0] rd_data, mdi;
  logic [23:0] mem_addr;
  logic [3:0] dl [3] = '{4'h1, 4'h2, 4'hf};
  csbc_cfg_t cfg;
  csbc_req_t req;
  int mismatches, cmp_count, lat, tot, items, stbs, bcks, base;
  csbc_chip_select_burst_config csbc_chip_select_burst_config_i (.clk(clk), .rstn(rstn),
    .cfg_load(cfg_load), .cfg_in(cfg), .req(req), .req_ready(req_ready),
    .done_len(done_len), .done(done), .rd_data(rd_data), .rd_valid(rd_valid),
    .mem_data_in(mdi), .burst_wait_input(bw), .mem_addr(mem_addr), .cs_n(cs_n),
    .address_valid_strobe_n(stb_n), .burst_clk(bclk));
  csbc_mem_model csbc_mem_model_i (.clk(clk), .mem_addr(mem_addr), .cs_n(cs_n),
    .wait_req(bw_on), .mem_data_in(mdi), .burst_wait_input(bw));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic setc(input logic p, y, input logic [3:0] d, input logic [1:0] n, z, w,
                      input logic [2:0] a);
    @(negedge clk);
    cfg = '{p, y, d, n, z, w, a};
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
  endtask
  task automatic acc(input logic wr, input logic [23:0] a, input logic [7:0] n, input int st);
    @(negedge clk);
    req = '{1'b1, wr, a, n};
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req.start = 1'b0;
    {lat, tot, items, stbs, bcks} = '0;
    // Bounded so a missing done pulse still ends the access
    while (done !== 1'b1 && tot < 300) begin
      if (rd_valid === 1'b1) begin
        if (items == 0) lat = tot;
        check("rd_data", rd_data, {8'ha5, 24'(a + st * items)});
        items++;
      end
      stbs += int'(stb_n === 1'b0);
      bcks += int'(bclk === 1'b1);
      @(negedge clk);
      tot++;
    end
    check("done", done, 1'b1);
  endtask
  task automatic rst();
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check("idle pins", {cs_n, bclk, req_ready}, 3'h5);
    acc(1'b0, 24'h000000, 8'h08, 1);
    check("len", done_len, 8'h08);
    check("bclk", bcks, 0);
    check("strobes", stbs, 8);
  endtask
  initial begin
    {cfg_load, cfg, req, bw_on} = '0;
    rst();
    for (int z = 0; z < 4; z++) begin
      setc(1'b1, 1'b1, 4'h0, 2'h0, z[1:0], 2'h2, 3'h0);
      acc(1'b0, 24'h000004, 8'h28, 4);
      check("page", done_len, (4 << z) - 1);
      check("strobes", stbs, (4 << z) - 1);
      check("bclk", bcks, 0);
    end
    setc(1'b1, 1'b1, 4'h0, 2'h0, 2'h0, 2'h1, 3'h0);
    acc(1'b0, 24'h000002, 8'h08, 2);
    check("half page", done_len, 8'h03);
    setc(1'b0, 1'b1, 4'h0, 2'h0, 2'h0, 2'h2, 3'h0);
    acc(1'b0, 24'h000010, 8'h02, 4);
    base = lat;
    check("sync bclk", bcks > 0, 1);
    foreach (dl[i]) begin
      setc(1'b0, 1'b1, dl[i], 2'h0, 2'h0, 2'h2, 3'h0);
      acc(1'b0, 24'h000010, 8'h01, 4);
      check("delay", lat - base, dl[i] - 1);
    end
    setc(1'b0, 1'b1, 4'h0, 2'h0, 2'h0, 2'h2, 3'h0);
    bw_on = 1'b1;
    fork
      acc(1'b0, 24'h000010, 8'h01, 4);
      begin
        repeat (4) @(negedge clk);
        bw_on = 1'b0;
      end
    join
    check("wait stall", lat - base, 3);
    setc(1'b0, 1'b0, 4'h0, 2'h0, 2'h0, 2'h2, 3'h0);
    acc(1'b0, 24'h000010, 8'h01, 4);
    base = lat;
    setc(1'b0, 1'b0, 4'hf, 2'h0, 2'h0, 2'h2, 3'h0);
    bw_on = 1'b1;
    acc(1'b0, 24'h000010, 8'h01, 4);
    bw_on = 1'b0;
    check("async delay", lat, base);
    acc(1'b1, 24'h000020, 8'h01, 4);
    base = tot;
    for (int n = 1; n < 4; n++) begin
      setc(1'b0, 1'b0, 4'h0, n[1:0], 2'h0, 2'h2, 3'h0);
      acc(1'b1, 24'h000020, 8'h01, 4);
      check("negate", tot - base, n);
    end
    setc(1'b0, 1'b0, 4'h0, 2'h3, 2'h0, 2'h2, 3'h1);
    acc(1'b1, 24'h000020, 8'h01, 4);
    check("negate assert delay", tot, base);
    setc(1'b1, 1'b1, 4'hf, 2'h3, 2'h3, 2'h2, 3'h0);
    rst();
    complete_run();
  end
  initial begin
    #100us;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
